// ### adc_ctrl_cfg.svh
// offsets, field positions, reset values, command codes and timing counts of the converter control
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
// apb byte offsets
`define OFS_CTRL      8'h00
`define OFS_CONV_CTRL 8'h04
`define OFS_RATE      8'h08
`define OFS_PERIOD    8'h0C
`define OFS_STATUS    8'h10
`define OFS_RESULT    8'h14
`define OFS_OFFSET    8'h18
`define OFS_GAIN      8'h1C
// field positions
`define CTRL_AUTO_CALIBRATE_BIT     0
`define CTRL_BUF      1
`define CLKOUT_HI     6
`define CLKOUT_LO     5
// reset values
`define CONV_CTRL_RST 8'h20
`define RATE_RST      8'hF0
`define PERIOD_RST    16'h0100
// serial commands
`define CMD_WAKEUP    8'h00
`define CMD_RDATA     8'h01
`define CMD_STREAM    8'h03
`define CMD_SDATAC    8'h0F
`define CMD_CALIB     8'hF0
`define CMD_SYNC      8'hFC
`define CMD_STANDBY   8'hFD
`define CMD_RESET     8'hFE
// timing counts
`define TIMEOUT_PER   6'h20
`define PDWN_PER      6'h14
`define CAL_PER       6'h04
`define UPDATE_CYC    8'h04
`define RESULT_BITS   5'h18
`define SCLK_RST_CYC  16'h0040
`endif

// ### adc_ctrl_pkg.sv
// types shared by the converter control logic
package adc_ctrl_pkg;
  typedef enum logic [2:0] {
    M_RUN  = 3'b000,
    M_CAL  = 3'b001,
    M_HALT = 3'b010,
    M_IDLE = 3'b011,
    M_PDWN = 3'b100,
    M_WAKE = 3'b101
  } mode_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic        sclk_d;
    mode_e       mode;
    logic        auto_cal;
    logic        buf_en;
    logic [7:0]  conv_ctrl;
    logic [7:0]  rate;
    logic [15:0] period;
    logic [23:0] ofs;
    logic [23:0] gain;
    logic [15:0] tmr;
    logic [7:0]  upd;
    logic [23:0] result;
    logic        rdy_n;
    logic [5:0]  cal_cnt;
    logic [5:0]  to_cnt;
    logic [5:0]  pd_cnt;
    logic [13:0] wake_cnt;
    logic [15:0] hi_cnt;
    logic [7:0]  sh_in;
    logic [2:0]  bitc;
    logic [23:0] sh_out;
    logic [4:0]  outc;
    logic        rd_active;
    logic        stream;
    logic        dout;
    logic        dout_oe;
    logic [2:0]  ck_div;
    logic        aux_clk;
    logic [31:0] prdata;
    logic        err;
  } state_s;
endpackage

// ### adc_ctrl.sv
// serial port, conversion-ready logic, sync, standby, power-down and resets of the converter
// How it works
// - chip select high resets the serial port and floats the data output.
// - serial clock low for 32 ready periods resets the serial port.
// - input sampled on falling serial clock, output launched on rising.
// - ready goes low on new result, high once 24 bits read.
// - ready high during result update; host must not read then.
// - with auto-calibration, ready stays high until calibration done and result valid.
// - leaving reset, sync, standby or power-down forces ready high until valid data.
// - align pin low across a ready-period tick then high restarts conversion on next master clock.
// - no serial communication accepted while align pin is low.
// - align pin low for 20 ready periods enters power-down.
// - halt command stops operation; resume syncs on its first serial clock.
// - idle command stops conversion, clock output keeps running; resume restarts.
// - leaving power-down waits 8192 master clocks before converting.
// - reset pin low forces reset; host holds it the minimum width.
// - reset command acts after its eighth bit and releases by itself.
// - serial clock pattern resets on its final falling edge, self-releasing.
// - any reset restores defaults; clock-out rate only by the reset pin. Offset and gain are not restored by pin or command resets.
// - every reset release is followed by a self-calibration.
// - power-up loads defaults then self-calibrates.
// - auto-calibration starts on a write changing rate, gain or buffer.
//
// The register addresses and the APB slave port were chosen for this implementation.
`include "adc_ctrl_cfg.svh"
module adc_ctrl #(
  parameter int WAKE_CYCLES = 8192
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // register bus
  input  wire adc_ctrl_pkg::apb_req_s apb_req,
  output adc_ctrl_pkg::apb_rsp_s      apb_rsp,
  // serial pins
  input  wire logic                  cs_n,
  input  wire logic                  sclk,
  input  wire logic                  din,
  output logic                       dout,
  output logic                       dout_oe,
  // control pins
  input  wire logic                  align_halt_pin,
  input  wire logic                  reset_pin_n,
  output logic                       conversion_ready_n,
  output logic                       aux_clock_out_pin,
  // analog front end
  input  wire logic [23:0]           conv_data,
  output logic                       analog_on
);
  import adc_ctrl_pkg::*;

  // copy of the reset value so that its fields can be selected
  localparam logic [7:0] ctl_default = `CONV_CTRL_RST;

  // wake counter is 14 bits wide
  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 16384) begin : g_bad_wake
    $error("WAKE_CYCLES out of range");
  end

  state_s r;
  state_s n;

  // state update
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r          <= '0;
      r.mode     <= M_CAL;
      r.conv_ctrl <= `CONV_CTRL_RST;
      r.rate     <= `RATE_RST;
      r.period   <= `PERIOD_RST;
      r.rdy_n    <= 1'b1;
      r.s1       <= 5'h1F;
      r.s2       <= 5'h1F;
    end else begin
      r <= n;
    end
  end

  // next-state logic
  always_comb begin
    logic       csn;
    logic       sck;
    logic       sdi;
    logic       aln;
    logic       rpin;
    logic       rise;
    logic       fall;
    logic       tick;
    logic       port_rst;
    logic       soft_rst;
    logic       restart;
    logic       start_cal;
    logic [7:0] cmd;
    logic       setup;
    csn       = r.s2[0];
    sck       = r.s2[1];
    sdi       = r.s2[2];
    aln       = r.s2[3];
    rpin      = r.s2[4];
    n         = r;
    soft_rst  = 1'b0;
    restart   = 1'b0;
    start_cal = 1'b0;
    rise      = 1'b0;
    fall      = 1'b0;
    tick      = 1'b0;
    port_rst  = 1'b0;
    cmd       = {r.sh_in[6:0], sdi};
    setup     = apb_req.psel && !apb_req.penable;

    // two-flop synchronisers; edges are found on the second stage only
    n.s1     = {reset_pin_n, align_halt_pin, din, sclk, cs_n};
    n.s2     = r.s1;
    n.sclk_d = sck;
    rise     = sck && !r.sclk_d;
    fall     = !sck && r.sclk_d;

    // ready-period timer keeps running outside power-down so timeouts can be counted
    tick = (r.tmr == r.period - 16'h0001) && (r.mode != M_PDWN);
    if (r.mode == M_PDWN) begin
      n.tmr = 16'h0000;
    end else if (tick) begin
      n.tmr = 16'h0000;
    end else begin
      n.tmr = r.tmr + 16'h0001;
    end

    // serial clock idle-low timeout
    if (sck || csn) begin
      n.to_cnt = 6'h00;
    end else if (tick && r.to_cnt != `TIMEOUT_PER) begin
      n.to_cnt = r.to_cnt + 6'h01;
    end
    port_rst = csn || !aln || (r.to_cnt == `TIMEOUT_PER) || (r.mode == M_PDWN);

    // serial clock held high long enough, then a falling edge, is the reset pattern
    if (!sck) begin
      n.hi_cnt = 16'h0000;
    end else if (r.hi_cnt != `SCLK_RST_CYC) begin
      n.hi_cnt = r.hi_cnt + 16'h0001;
    end
    if (fall && r.hi_cnt == `SCLK_RST_CYC && !csn) begin
      soft_rst = 1'b1;
    end

    // serial port
    if (port_rst) begin
      n.bitc      = 3'h0;
      n.sh_in     = 8'h00;
      n.rd_active = 1'b0;
      n.dout_oe   = 1'b0;
    end else begin
      // resume from halt or idle on the first clock of the next byte
      if (rise && r.bitc == 3'h0 && (r.mode == M_HALT || r.mode == M_IDLE)) begin
        restart = 1'b1;
        n.mode  = M_RUN;
      end
      if (rise && r.rd_active) begin
        n.dout    = r.sh_out[23];
        n.dout_oe = 1'b1;
        n.sh_out  = {r.sh_out[22:0], 1'b0};
        n.outc    = r.outc + 5'h01;
        if (r.outc == `RESULT_BITS - 5'h01) begin
          n.rd_active = 1'b0;
          n.rdy_n     = 1'b1;
        end
      end
      if (fall) begin
        if (!r.rd_active) begin
          n.dout_oe = 1'b0;
        end
        n.sh_in = cmd;
        n.bitc  = r.bitc + 3'h1;
        if (r.bitc == 3'h7 && !r.rd_active) begin
          case (cmd)
            `CMD_RDATA, `CMD_STREAM: begin
              n.sh_out    = r.result;
              n.outc      = 5'h00;
              n.rd_active = 1'b1;
              n.stream    = (cmd == `CMD_STREAM) || r.stream;
            end
            `CMD_SDATAC:  n.stream = 1'b0;
            `CMD_SYNC:    n.mode   = M_HALT;
            `CMD_STANDBY: n.mode   = M_IDLE;
            `CMD_CALIB:   start_cal = 1'b1;
            `CMD_RESET:   soft_rst  = 1'b1;
            default:      n.bitc    = 3'h0;
          endcase
        end else if (r.bitc == 3'h7 && cmd == `CMD_SDATAC) begin
          n.stream = 1'b0;
        end
      end
    end

    // align pin: hold, count to power-down, resync or wake on release
    if (!aln) begin
      if (r.mode != M_PDWN) begin
        n.rdy_n  = 1'b1;
        n.upd    = 8'h00;
        if (tick) begin
          n.pd_cnt = r.pd_cnt + 6'h01;
        end
        if (r.pd_cnt == `PDWN_PER) begin
          n.mode = M_PDWN;
        end
      end
    end else begin
      n.pd_cnt = 6'h00;
      if (r.mode == M_PDWN) begin
        n.mode     = M_WAKE;
        n.wake_cnt = 14'h0000;
      end else if (r.pd_cnt != 6'h00 && r.mode == M_RUN) begin
        restart = 1'b1;
      end
    end

    // wake delay after power-down
    if (r.mode == M_WAKE) begin
      n.wake_cnt = r.wake_cnt + 14'h0001;
      if (r.wake_cnt == 14'(WAKE_CYCLES - 1)) begin
        n.mode  = M_RUN;
        restart = 1'b1;
      end
    end

    // conversions: update window keeps ready high, then the result is latched
    if (r.upd != 8'h00) begin
      n.upd = r.upd - 8'h01;
      if (r.upd == 8'h01) begin
        n.result = conv_data;
        n.rdy_n  = 1'b0;
        if (r.stream && !port_rst) begin
          n.sh_out    = conv_data;
          n.outc      = 5'h00;
          n.rd_active = 1'b1;
        end
      end
    end else if (tick && r.mode == M_RUN && aln) begin
      n.upd       = `UPDATE_CYC;
      n.rdy_n     = 1'b1;
      n.rd_active = 1'b0;
    end

    // self-calibration runs a fixed number of ready periods with ready held high
    if (r.mode == M_CAL) begin
      n.rdy_n  = 1'b1;
      if (!rpin) begin
        n.cal_cnt = 6'h00;
      end else if (tick) begin
        n.cal_cnt = r.cal_cnt + 6'h01;
        if (r.cal_cnt == `CAL_PER - 6'h01) begin
          n.mode  = M_RUN;
          restart = 1'b1;
        end
      end
    end

    // apb: read data captured in setup, writes in the access phase
    n.prdata = 32'h0000_0000;
    n.err    = 1'b0;
    if (setup) begin
      case (apb_req.paddr)
        `OFS_CTRL:   n.prdata[1:0] = {r.buf_en, r.auto_cal};
        `OFS_CONV_CTRL: n.prdata[7:0] = r.conv_ctrl;
        `OFS_RATE:   n.prdata[7:0] = r.rate;
        `OFS_PERIOD: n.prdata[15:0] = r.period;
        `OFS_STATUS: n.prdata[6:0] = {r.stream, r.rd_active, 1'b0, r.mode, r.rdy_n};
        `OFS_RESULT: n.prdata[23:0] = r.result;
        `OFS_OFFSET: n.prdata[23:0] = r.ofs;
        `OFS_GAIN:   n.prdata[23:0] = r.gain;
        default:     n.err = 1'b1;
      endcase
    end else begin
      n.err = r.err && apb_req.psel;
    end
    if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
      case (apb_req.paddr)
        `OFS_CTRL: begin
          n.auto_cal = apb_req.pwdata[`CTRL_AUTO_CALIBRATE_BIT];
          n.buf_en   = apb_req.pwdata[`CTRL_BUF];
          if (apb_req.pwdata[`CTRL_AUTO_CALIBRATE_BIT] && apb_req.pwdata[`CTRL_BUF] != r.buf_en) begin
            start_cal = 1'b1;
          end
        end
        `OFS_CONV_CTRL: begin
          n.conv_ctrl = {1'b0, apb_req.pwdata[6:0]};
          if (r.auto_cal && apb_req.pwdata[2:0] != r.conv_ctrl[2:0]) begin
            start_cal = 1'b1;
          end
        end
        `OFS_RATE: begin
          n.rate = apb_req.pwdata[7:0];
          if (r.auto_cal && apb_req.pwdata[7:0] != r.rate) begin
            start_cal = 1'b1;
          end
        end
        `OFS_PERIOD: begin
          // a zero period would stretch the timer to 65536 cycles, so it is clamped to one
          n.period = (apb_req.pwdata[15:0] == 16'h0000) ? 16'h0001 : apb_req.pwdata[15:0];
        end
        `OFS_OFFSET: n.ofs  = apb_req.pwdata[23:0];
        `OFS_GAIN:   n.gain = apb_req.pwdata[23:0];
        default:     n.err  = r.err;
      endcase
    end

    // restart of conversion: timer cleared, ready forced high until first result
    if (restart) begin
      n.tmr    = 16'h0000;
      n.upd    = 8'h00;
      n.rdy_n  = 1'b1;
    end

    // calibration entry, also the tail of every reset
    if (start_cal && r.mode != M_PDWN) begin
      n.mode    = M_CAL;
      n.cal_cnt = 6'h00;
      n.tmr     = 16'h0000;
      n.upd     = 8'h00;
      n.rdy_n   = 1'b1;
    end

    // soft and pin resets restore defaults except offset and gain; only the pin restores the clock-out rate
    if (soft_rst || !rpin) begin
      n.auto_cal  = 1'b0;
      n.buf_en    = 1'b0;
      n.conv_ctrl = {ctl_default[7], r.conv_ctrl[`CLKOUT_HI:`CLKOUT_LO], ctl_default[4:0]};
      n.rate      = `RATE_RST;
      n.period    = `PERIOD_RST;
      n.stream    = 1'b0;
      n.rd_active = 1'b0;
      n.dout_oe   = 1'b0;
      n.bitc      = 3'h0;
      n.mode      = M_CAL;
      n.cal_cnt   = 6'h00;
      n.tmr       = 16'h0000;
      n.upd       = 8'h00;
      n.rdy_n     = 1'b1;
      if (!rpin) begin
        n.conv_ctrl = `CONV_CTRL_RST;
      end
    end

    // clock output divider stops only in power-down
    n.ck_div = (r.mode == M_PDWN) ? 3'h0 : r.ck_div + 3'h1;
    case (r.conv_ctrl[`CLKOUT_HI:`CLKOUT_LO])
      2'b01:   n.aux_clk = n.ck_div[0];
      2'b10:   n.aux_clk = n.ck_div[1];
      2'b11:   n.aux_clk = n.ck_div[2];
      default: n.aux_clk = 1'b0;
    endcase
  end

  // outputs
  assign dout               = r.dout;
  assign dout_oe            = r.dout_oe;
  assign conversion_ready_n = r.rdy_n;
  assign aux_clock_out_pin  = r.aux_clk;
  // a held align pin stops conversion, so the front end is off then too
  assign analog_on          = ((r.mode == M_RUN) || (r.mode == M_CAL)) && r.s2[3];
  assign apb_rsp.pready     = apb_req.psel && apb_req.penable;
  assign apb_rsp.prdata     = r.prdata;
  assign apb_rsp.pslverr    = apb_req.psel && apb_req.penable && r.err;
endmodule

// ### adc_ctrl_asserts.sv
// checker on the converter control pins
module adc_ctrl_asserts
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic     sys_clk,
  input wire logic     nrst,
  // register bus
  input wire apb_req_s apb_req,
  input wire apb_rsp_s apb_rsp,
  // serial and control pins
  input wire logic     cs_n,
  input wire logic     sclk,
  input wire logic     dout,
  input wire logic     dout_oe,
  input wire logic     align_halt_pin,
  input wire logic     reset_pin_n,
  input wire logic     conversion_ready_n,
  input wire logic     analog_on
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // five cycles cover the two-flop pin synchronisers plus the output register
  a_cs_float: assert property (cs_n [*5] |-> !dout_oe) else $error("dout driven while deselected");
  a_dout_launch: assert property ($changed(dout) && dout_oe && $past(dout_oe)
    |-> $past(sclk, 2) && $past(sclk, 3)) else $error("dout moved off a rising sclk");
  a_upd_window: assert property ($fell(conversion_ready_n)
    |-> $past(conversion_ready_n, 2) && $past(conversion_ready_n, 4))
    else $error("update window too short");
  a_halt_quiet: assert property (!align_halt_pin [*5] |-> !dout_oe)
    else $error("serial port active while halted");
  a_halt_ready: assert property (!align_halt_pin [*5] |-> conversion_ready_n)
    else $error("ready low while halted");
  a_halt_analog: assert property (!align_halt_pin [*5] |-> !analog_on)
    else $error("front end on while halted");
  a_pin_reset: assert property (!reset_pin_n [*5] |-> conversion_ready_n && !dout_oe)
    else $error("reset pin ignored");
  a_bus_refuse: assert property (apb_req.psel && apb_req.penable && !apb_req.pwrite
    && apb_req.paddr > 8'h1C |-> apb_rsp.pready && apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped read not refused");
  c_ready: cover property ($fell(conversion_ready_n));
  c_drive: cover property ($rose(dout_oe));
  c_refuse: cover property (apb_rsp.pslverr);
endmodule
bind adc_ctrl adc_ctrl_asserts chk (.sys_clk(sys_clk), .nrst(nrst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe(dout_oe),
  .align_halt_pin(align_halt_pin), .reset_pin_n(reset_pin_n),
  .conversion_ready_n(conversion_ready_n), .analog_on(analog_on));

// ### host_link.sv
// host side of the serial link: frames commands and clocks out results
module host_link (
  // serial pins
  output logic     cs_n,
  output logic     sclk,
  output logic     din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b1;
  end
  // a few stray clocks left unfinished, chip select stays low
  task automatic stray(input int nb);
    #37 cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      #400 sclk = 1'b1;
      #400 sclk = 1'b0;
    end
  endtask
  // sclk held high well past the reset length, then one falling edge
  task automatic sclk_reset;
    #37 cs_n = 1'b0;
    #400 sclk = 1'b1;
    #8000 sclk = 1'b0;
    #400 cs_n = 1'b1;
    #400;
  endtask
  // one frame: command byte msb first, then nrd readout bits; sclk idles low between frames
  // the stream command is never sent, so a shared data wire would stay safe
  task automatic frame(input logic [7:0] cmd, input int nrd, output logic [23:0] rd);
    #37 cs_n = 1'b0;
    #400;
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      din  = cmd[i];
      #400 sclk = 1'b0;
      #400;
    end
    rd = 24'h0;
    for (int i = 0; i < nrd; i++) begin
      sclk = 1'b1;
      #400 sclk = 1'b0;
      #400 rd = {rd[22:0], dout};
    end
    din  = ~din; // released line must not keep the last bit
    cs_n = 1'b1;
    #400;
  endtask
endmodule

// ### testbench.sv
// self-checking bench of the converter control block
`include "adc_ctrl_cfg.svh"
module testbench;
  import adc_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, nrst, cs_n, sclk, din, dout, dout_oe, align_halt_pin, reset_pin_n;
  logic conversion_ready_n, aux_clock_out_pin, analog_on, er, a1;
  logic dout_line;
  logic [23:0] conv_data, d;
  logic [31:0] r;
  apb_req_s apb_req;
  apb_rsp_s apb_rsp;
  int miscompares = 0;
  int n_compared = 0;
  adc_ctrl #(.WAKE_CYCLES(16)) uut (.sys_clk(sys_clk), .nrst(nrst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .align_halt_pin(align_halt_pin), .reset_pin_n(reset_pin_n),
    .conversion_ready_n(conversion_ready_n), .aux_clock_out_pin(aux_clock_out_pin),
    .conv_data(conv_data), .analog_on(analog_on));
  // a released data line floats up to its pull-up
  assign dout_line = dout_oe ? dout : 1'b1;
  host_link host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_line));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // apb transfer; request held until pready is seen high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) miscompares++;
    r  = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, r);
  endtask
  task automatic mchk(input mode_e m);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk("mode", {29'h0, m}, {28'h0, r[4:1]});
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    while (conversion_ready_n !== 1'b0 && n < 8000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("ready", 32'h0, {31'h0, conversion_ready_n});
  endtask
  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard: the whole sequence needs a little under a millisecond
  initial begin
    #3ms miscompares++;
    end_sim();
  end
  initial begin
    apb_req = '0;
    nrst = 1'b0;
    align_halt_pin = 1'b1;
    reset_pin_n = 1'b1;
    conv_data = 24'hA5C3E1;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rchk(`OFS_CONV_CTRL, {24'h0, `CONV_CTRL_RST});
    rchk(`OFS_RATE, {24'h0, `RATE_RST});
    rchk(`OFS_PERIOD, {16'h0, `PERIOD_RST});
    mchk(M_CAL);
    rchk(8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    bus(1'b1, `OFS_PERIOD, 32'h0200);
    wait_rdy();
    host.frame(`CMD_RDATA, 24, d);
    chk("result", {8'h0, conv_data}, {8'h0, d});
    chk("ready after read", 32'h1, {31'h0, conversion_ready_n});
    repeat (5) @(posedge sys_clk);
    chk("float", 32'h0, {31'h0, dout_oe});
    // rate change then sync; halt and idle commands, each resumed by the wake command
    bus(1'b1, `OFS_RATE, 32'h00E0);
    for (int i = 0; i < 2; i++) begin
      host.frame(i ? `CMD_STANDBY : `CMD_SYNC, 0, d);
      mchk(i ? M_IDLE : M_HALT);
      chk("analog", 32'h0, {31'h0, analog_on});
      a1 = aux_clock_out_pin;
      @(posedge sys_clk);
      chk("aux", {31'h0, ~a1}, {31'h0, aux_clock_out_pin});
      host.frame(`CMD_WAKEUP, 0, d);
      chk("ready held", 32'h1, {31'h0, conversion_ready_n});
      wait_rdy();
    end
    bus(1'b1, `OFS_CTRL, 32'h3);
    mchk(M_CAL);
    wait_rdy();
    // pin halt long enough to power down; a frame meanwhile must go unanswered
    bus(1'b1, `OFS_PERIOD, 32'h0010);
    // a broken-off byte is forgotten after the idle timeout
    host.stray(3);
    repeat (600) @(posedge sys_clk);
    host.frame(`CMD_SYNC, 0, d);
    mchk(M_HALT);
    host.frame(`CMD_WAKEUP, 0, d);
    align_halt_pin <= 1'b0;
    host.frame(`CMD_RDATA, 24, d);
    chk("halted read", 32'h00FFFFFF, {8'h0, d});
    repeat (400) @(posedge sys_clk);
    mchk(M_PDWN);
    align_halt_pin <= 1'b1;
    wait_rdy();
    bus(1'b1, `OFS_CONV_CTRL, 32'h67);
    host.frame(`CMD_RESET, 0, d);
    rchk(`OFS_CONV_CTRL, 32'h60);
    rchk(`OFS_PERIOD, {16'h0, `PERIOD_RST});
    mchk(M_CAL);
    bus(1'b1, `OFS_RATE, 32'h0033);
    host.sclk_reset();
    rchk(`OFS_RATE, {24'h0, `RATE_RST});
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    rchk(`OFS_CONV_CTRL, {24'h0, `CONV_CTRL_RST});
    end_sim();
  end
endmodule
